// ==== logic/dwcsr_ctrl.sv ====
// Purpose: write/verify command interpreter with status and retry sequencing
// Assumes: host strobes come from a bus front-end on mclk; drive status pins are asynchronous
// Notes:   ctrlBusyLine high means idle, low means busy
`timescale 1ns/100ps
module dwcsr_ctrl (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       cmdWrStb,
	input  wire logic       dataWrStb,
	input  wire logic       dataRdStb,
	input  wire logic [7:0] hostWrData,
	output logic      [7:0] hostRdData,
	output logic            ctrlBusyLine,
	output logic            hostAlert,
	output logic            hostDataReq,
	output logic            opStart,
	output logic      [3:0] opKind,
	output logic      [1:0] opUnit,
	output logic      [3:0] opHead,
	output logic     [10:0] opCyl,
	output logic      [7:0] opSector,
	output logic      [7:0] opSecCount,
	output logic            opTrackMode,
	output logic      [1:0] posShift,
	input  wire logic       opDone,
	input  wire logic [3:0] opErr,
	input  wire logic       eccFitted,
	input  wire logic [7:0] secPerTrack,
	output logic            fmtSpared,
	output logic      [7:0] fmtAddrMark,
	output logic      [7:0] fmtSpareSlot,
	input  wire logic [3:0] hdrHead,
	input  wire logic [7:0] hdrCylLo,
	input  wire logic [7:0] hdrCylHi,
	input  wire logic [7:0] hdrSector,
	input  wire logic [7:0] hdrMark,
	input  wire logic       driveReadyPin,
	input  wire logic       driveFaultPin,
	input  wire logic       driveIllegalPin,
	input  wire logic       seekDonePin,
	output logic      [7:0] diskData,
	output logic            diskValid,
	input  wire logic       diskReady
);
	dwcsr_pkg::dwcsr_state_t state_reg;
	dwcsr_pkg::dwcsr_op_t    opKind_reg, mainOp, checkOp;
	logic [7:0] param_reg [dwcsr_pkg::NUM_PARAMS];
	logic [7:0] cmd_reg, curSector_reg, secLeft_reg, inBuf_reg, mark_reg, aux1_reg, auxNext;
	logic [3:0] tryCnt_reg, flags_reg, errCode_reg, statIdx_reg, syncA_reg, syncB_reg, statNext;
	logic [2:0] paramIdx_reg;
	logic [1:0] offLvl_reg, termPh_reg, shift_reg;
	logic       opStart_reg, eccTried_reg, snfTried_reg, fltTried_reg, alert_reg, busyLine_reg, spared_reg;
	logic       cmdTake, goTake, writeCmd, retryOn, rawOn, fifoInReady;

	// termination byte: code clamped to 0-9, flags only on success
	function automatic logic [7:0] fnTermByte(input logic [3:0] code, input logic [3:0] flg);
		logic [3:0] c;
		c = (code > dwcsr_pkg::ERR_TMO) ? dwcsr_pkg::ERR_TMO : code;
		fnTermByte = {(c == dwcsr_pkg::ERR_NONE) ? flg : 4'h0, c};
	endfunction : fnTermByte

	// command byte decode
	function automatic logic fnIsClass(input logic [7:0] c, input logic [1:0] cls);
		fnIsClass = (c[1:0] == cls);
	endfunction : fnIsClass

	// mode terms from the latched command
	assign writeCmd = cmd_reg[dwcsr_pkg::BIT_WRITE];
	assign retryOn  = !cmd_reg[dwcsr_pkg::BIT_DIRECT] && !cmd_reg[dwcsr_pkg::BIT_NORTRY];
	assign rawOn    = !cmd_reg[dwcsr_pkg::BIT_DIRECT] && cmd_reg[dwcsr_pkg::BIT_RAW];
	assign mainOp   = writeCmd ? dwcsr_pkg::OP_WRITE : dwcsr_pkg::OP_COMPARE;
	assign checkOp  = writeCmd ? dwcsr_pkg::OP_READBACK : dwcsr_pkg::OP_COMPARE;
	assign cmdTake  = cmdWrStb && (state_reg == dwcsr_pkg::S_IDLE || state_reg == dwcsr_pkg::S_PARAM
	                  || state_reg == dwcsr_pkg::S_STAT);
	assign goTake   = dataWrStb && state_reg == dwcsr_pkg::S_PARAM
	                  && paramIdx_reg == 3'(dwcsr_pkg::NUM_PARAMS);

	// host-visible outputs
	assign hostRdData   = inBuf_reg;
	assign ctrlBusyLine = busyLine_reg;
	assign hostAlert    = alert_reg;
	assign hostDataReq  = fifoInReady && state_reg == dwcsr_pkg::S_WAIT;
	assign opStart      = opStart_reg;
	assign opKind       = opKind_reg;
	assign opUnit       = param_reg[0][1:0];
	assign opHead       = param_reg[0][7:4];
	assign opCyl        = {param_reg[2][2:0], param_reg[1]};
	assign opSector     = curSector_reg;
	assign opSecCount   = secLeft_reg;
	assign opTrackMode  = cmd_reg[dwcsr_pkg::BIT_TRACK];
	assign posShift     = shift_reg;
	assign fmtSpared    = spared_reg;
	assign fmtAddrMark  = mark_reg;
	assign fmtSpareSlot = param_reg[5];

	// host data into the sector path
	dwcsr_fifo #(
		.WIDTH (8),
		.DEPTH (8)
	) u_fifo (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.inData   (hostWrData),
		.inValid  (dataWrStb && state_reg == dwcsr_pkg::S_WAIT),
		.inReady  (fifoInReady),
		.outData  (diskData),
		.outValid (diskValid),
		.outReady (diskReady)
	);

	// drive status pins through two flops
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{syncA_reg, syncB_reg} <= '0;
		end else begin
			syncA_reg <= {seekDonePin, driveFaultPin, driveIllegalPin, driveReadyPin};
			syncB_reg <= syncA_reg;
		end
	end

	// command and parameter intake
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_reg      <= '0;
			paramIdx_reg <= '0;
			for (int i = 0; i < dwcsr_pkg::NUM_PARAMS; i++) begin
				param_reg[i] <= '0;
			end
		end else if (cmdTake) begin
			cmd_reg      <= hostWrData;
			paramIdx_reg <= '0;
		end else if (dataWrStb && state_reg == dwcsr_pkg::S_PARAM && !goTake) begin
			param_reg[paramIdx_reg] <= hostWrData;
			paramIdx_reg            <= paramIdx_reg + 1'b1;
		end
	end

	// offset and format outputs
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg  <= '0;
			mark_reg   <= dwcsr_pkg::MARK_NORM;
			spared_reg <= 1'b0;
		end else begin
			if (offLvl_reg != 2'h0) begin
				shift_reg <= (offLvl_reg == 2'h1) ? 2'b01 : 2'b10;
			end else if (fnIsClass(cmd_reg, dwcsr_pkg::CLS_READ)
			             && (cmd_reg[dwcsr_pkg::BIT_DIRECT] || cmd_reg[dwcsr_pkg::BIT_NORTRY])) begin
				shift_reg <= {param_reg[2][dwcsr_pkg::BIT_OFFM], param_reg[2][dwcsr_pkg::BIT_OFFP]};
			end else begin
				shift_reg <= 2'b00;
			end
			spared_reg <= (param_reg[5] < secPerTrack);
			mark_reg   <= (param_reg[5] < secPerTrack) ? dwcsr_pkg::MARK_SPARE : dwcsr_pkg::MARK_NORM;
		end
	end

	// sequencer: start, per-sector operation, retry ladder, termination
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg  <= dwcsr_pkg::S_IDLE;
			opKind_reg <= dwcsr_pkg::OP_SEEK;
			{curSector_reg, secLeft_reg, tryCnt_reg, offLvl_reg, flags_reg, errCode_reg, termPh_reg} <= '0;
			{opStart_reg, eccTried_reg, snfTried_reg, fltTried_reg} <= '0;
		end else begin
			opStart_reg <= 1'b0;
			case (state_reg)
			dwcsr_pkg::S_IDLE, dwcsr_pkg::S_STAT: begin
				if (cmdTake) begin
					state_reg <= dwcsr_pkg::S_PARAM;
				end
			end
			dwcsr_pkg::S_PARAM: begin
				if (goTake) begin
					curSector_reg <= param_reg[3];
					secLeft_reg   <= param_reg[4];
					{tryCnt_reg, offLvl_reg, flags_reg, termPh_reg} <= '0;
					{eccTried_reg, snfTried_reg, fltTried_reg} <= '0;
					if (!fnIsClass(cmd_reg, dwcsr_pkg::CLS_WRITE)) begin
						errCode_reg <= dwcsr_pkg::ERR_CMD;
						state_reg   <= dwcsr_pkg::S_TERM;
					end else if (param_reg[2][4:3] != 2'b00) begin
						errCode_reg <= dwcsr_pkg::ERR_PARAM;
						state_reg   <= dwcsr_pkg::S_TERM;
					end else if (!syncB_reg[0]) begin
						errCode_reg <= dwcsr_pkg::ERR_NRDY;
						state_reg   <= dwcsr_pkg::S_TERM;
					end else begin
						errCode_reg <= dwcsr_pkg::ERR_NONE;
						opKind_reg  <= cmd_reg[dwcsr_pkg::BIT_SEEK] ? dwcsr_pkg::OP_SEEK : mainOp;
						opStart_reg <= 1'b1;
						state_reg   <= dwcsr_pkg::S_WAIT;
					end
				end else if (cmdTake) begin
					state_reg <= dwcsr_pkg::S_PARAM;
				end
			end
			dwcsr_pkg::S_WAIT: begin
				if (opDone) begin
					opStart_reg <= 1'b1;
					if (opErr == dwcsr_pkg::ERR_NONE) begin
						case (opKind_reg)
						dwcsr_pkg::OP_RECAL: begin
							flags_reg[0] <= 1'b1;
							opKind_reg   <= dwcsr_pkg::OP_SEEK;
						end
						dwcsr_pkg::OP_SEEK: opKind_reg <= mainOp;
						dwcsr_pkg::OP_FLTCLR: begin
							flags_reg[1] <= 1'b1;
							opKind_reg   <= mainOp;
						end
						dwcsr_pkg::OP_REWRITE: opKind_reg <= checkOp;
						default: begin
							if (opKind_reg == dwcsr_pkg::OP_WRITE && rawOn) begin
								opKind_reg <= dwcsr_pkg::OP_READBACK;
							end else begin
								if (opKind_reg == dwcsr_pkg::OP_ECC) begin
									flags_reg[3] <= 1'b1;
								end
								if (cmd_reg[dwcsr_pkg::BIT_TRACK] || secLeft_reg <= 8'h01) begin
									opStart_reg <= 1'b0;
									state_reg   <= dwcsr_pkg::S_TERM;
								end else begin
									secLeft_reg   <= secLeft_reg - 1'b1;
									curSector_reg <= curSector_reg + 1'b1;
									{tryCnt_reg, offLvl_reg} <= '0;
									{eccTried_reg, snfTried_reg, fltTried_reg} <= '0;
									opKind_reg    <= mainOp;
								end
							end
						end
						endcase
					end else if (!retryOn) begin
						opStart_reg <= 1'b0;
						errCode_reg <= opErr;
						state_reg   <= dwcsr_pkg::S_TERM;
					end else if (rawOn && tryCnt_reg < dwcsr_pkg::MAX_TRIES
					             && (opKind_reg == dwcsr_pkg::OP_READBACK || opErr == dwcsr_pkg::ERR_CMP)) begin
						tryCnt_reg   <= tryCnt_reg + 1'b1;
						flags_reg[2] <= 1'b1;
						opKind_reg   <= dwcsr_pkg::OP_REWRITE;
					end else if (opErr == dwcsr_pkg::ERR_DATA && eccFitted && !eccTried_reg) begin
						eccTried_reg <= 1'b1;
						opKind_reg   <= dwcsr_pkg::OP_ECC;
					end else if (opErr == dwcsr_pkg::ERR_DATA && tryCnt_reg < dwcsr_pkg::MAX_TRIES) begin
						tryCnt_reg   <= tryCnt_reg + 1'b1;
						eccTried_reg <= 1'b0;
						flags_reg[2] <= 1'b1;
						opKind_reg   <= mainOp;
					end else if (opErr == dwcsr_pkg::ERR_DATA && offLvl_reg < dwcsr_pkg::MAX_OFFSET) begin
						offLvl_reg   <= offLvl_reg + 1'b1;
						tryCnt_reg   <= '0;
						eccTried_reg <= 1'b0;
						flags_reg[2] <= 1'b1;
						opKind_reg   <= mainOp;
					end else if (opErr == dwcsr_pkg::ERR_SNF && !snfTried_reg) begin
						snfTried_reg <= 1'b1;
						flags_reg[2] <= 1'b1;
						opKind_reg   <= dwcsr_pkg::OP_RECAL;
					end else if (opErr == dwcsr_pkg::ERR_FAULT && writeCmd && !fltTried_reg) begin
						fltTried_reg <= 1'b1;
						flags_reg[2] <= 1'b1;
						opKind_reg   <= dwcsr_pkg::OP_FLTCLR;
					end else begin
						opStart_reg <= 1'b0;
						errCode_reg <= opErr;
						state_reg   <= dwcsr_pkg::S_TERM;
					end
				end
			end
			dwcsr_pkg::S_TERM: begin
				termPh_reg <= termPh_reg + 1'b1;
				if (termPh_reg == 2'h2) begin
					state_reg <= dwcsr_pkg::S_STAT;
				end
			end
			default: state_reg <= dwcsr_pkg::S_IDLE;
			endcase
		end
	end

	// next status byte for a data-port read
	always_comb begin
		statNext = (statIdx_reg >= dwcsr_pkg::AUX_FILL) ? dwcsr_pkg::AUX_FILL : statIdx_reg + 1'b1;
		case (statNext)
		4'h1: auxNext = aux1_reg;
		4'h2: auxNext = cmd_reg;
		4'h3: auxNext = {hdrHead, 2'b00, param_reg[0][1:0]};
		4'h4: auxNext = hdrCylLo;
		4'h5: auxNext = hdrCylHi;
		4'h6: auxNext = hdrSector;
		4'h7: auxNext = hdrMark;
		default: auxNext = dwcsr_pkg::FILL_BYTE;
		endcase
	end

	// input buffer, busy line and alert
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{inBuf_reg, statIdx_reg, aux1_reg} <= '0;
			alert_reg    <= 1'b0;
			busyLine_reg <= 1'b1;
		end else begin
			if (cmdTake) begin
				inBuf_reg <= hostWrData;
				alert_reg <= 1'b0;
			end else if (dataWrStb && state_reg == dwcsr_pkg::S_PARAM && !goTake) begin
				inBuf_reg <= hostWrData;
			end
			if (goTake) begin
				busyLine_reg <= 1'b0;
			end
			if (state_reg == dwcsr_pkg::S_TERM) begin
				case (termPh_reg)
				2'h0: begin
					busyLine_reg <= 1'b1;
					aux1_reg     <= {syncB_reg[3], syncB_reg[2], syncB_reg[1], 2'b00, !syncB_reg[0], 2'b00};
				end
				2'h1: alert_reg <= 1'b1;
				default: begin
					inBuf_reg   <= fnTermByte(errCode_reg, flags_reg);
					statIdx_reg <= '0;
				end
				endcase
			end else if (state_reg == dwcsr_pkg::S_STAT && dataRdStb && !cmdWrStb) begin
				if (statIdx_reg == 4'h0) begin
					alert_reg <= 1'b0;
				end
				statIdx_reg <= statNext;
				inBuf_reg   <= auxNext;
			end
		end
	end
endmodule : dwcsr_ctrl

// ==== logic/dwcsr_pkg.sv ====
// Purpose: shared constants for the write/verify command interpreter
// Assumes: 8-bit host bytes, 10 MHz mclk
// Notes:   error codes and bit positions as seen by the host
package dwcsr_pkg;
	// command byte fields
	localparam logic [1:0] CLS_WRITE  = 2'h3;
	localparam logic [1:0] CLS_READ   = 2'h2;
	localparam int         BIT_WRITE  = 2;
	localparam int         BIT_RAW    = 3;
	localparam int         BIT_TRACK  = 4;
	localparam int         BIT_DIRECT = 5;
	localparam int         BIT_SEEK   = 6;
	localparam int         BIT_NORTRY = 7;
	// parameter byte fields
	localparam int         NUM_PARAMS = 6;
	localparam int         BIT_OFFP   = 6;
	localparam int         BIT_OFFM   = 7;
	// termination error codes
	localparam logic [3:0] ERR_NONE   = 4'h0;
	localparam logic [3:0] ERR_CMD    = 4'h1;
	localparam logic [3:0] ERR_PARAM  = 4'h2;
	localparam logic [3:0] ERR_NRDY   = 4'h3;
	localparam logic [3:0] ERR_FAULT  = 4'h4;
	localparam logic [3:0] ERR_ILL    = 4'h5;
	localparam logic [3:0] ERR_SNF    = 4'h6;
	localparam logic [3:0] ERR_DATA   = 4'h7;
	localparam logic [3:0] ERR_CMP    = 4'h8;
	localparam logic [3:0] ERR_TMO    = 4'h9;
	// address marks
	localparam logic [7:0] MARK_NORM  = 8'h77;
	localparam logic [7:0] MARK_SPARE = 8'h7D;
	// retry limits, status byte indices and filler byte
	localparam logic [3:0] MAX_TRIES  = 4'hA;
	localparam logic [1:0] MAX_OFFSET = 2'h2;
	localparam logic [3:0] AUX_LAST   = 4'h7;
	localparam logic [3:0] AUX_FILL   = 4'h8;
	localparam logic [7:0] FILL_BYTE  = 8'h00;
	// operations asked of the disk engine
	typedef enum logic [3:0] {
		OP_SEEK     = 4'h0,
		OP_WRITE    = 4'h1,
		OP_COMPARE  = 4'h2,
		OP_READBACK = 4'h3,
		OP_REWRITE  = 4'h4,
		OP_RECAL    = 4'h5,
		OP_FLTCLR   = 4'h6,
		OP_ECC      = 4'h7
	} dwcsr_op_t;
	typedef enum logic [4:0] {
		S_IDLE  = 5'b00001,
		S_PARAM = 5'b00010,
		S_WAIT  = 5'b00100,
		S_TERM  = 5'b01000,
		S_STAT  = 5'b10000
	} dwcsr_state_t;
endpackage : dwcsr_pkg

// ==== logic/dwcsr_fifo.sv ====
// Purpose: small data FIFO between host bytes and the disk engine
// Assumes: single clock, synchronous push and pop
// Notes:   full and empty are exact; in ready drops when full
`timescale 1ns/100ps
module dwcsr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      fill_reg;
	logic             push;
	logic             pop;

	// handshake terms
	assign inReady  = (fill_reg != (AW+1)'(DEPTH));
	assign outValid = (fill_reg != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = mem[rdPtr_reg];

	// storage
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// pointers and fill level
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			fill_reg  <= '0;
		end else begin
			if (push) begin
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
			end
			if (push && !pop) begin
				fill_reg <= fill_reg + 1'b1;
			end else if (pop && !push) begin
				fill_reg <= fill_reg - 1'b1;
			end
		end
	end
endmodule : dwcsr_fifo

// ==== verification/dwcsr_props.sv ====
// Purpose: concurrent checks on the interpreter's host and format outputs
// Assumes: one mclk domain, arst_n asynchronous active low
// Notes:   bound to dwcsr_ctrl below
`timescale 1ns/100ps
module dwcsr_props (
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic       cmdWrStb,
	input wire logic       dataRdStb,
	input wire logic [7:0] hostRdData,
	input wire logic       ctrlBusyLine,
	input wire logic       hostAlert,
	input wire logic       hostDataReq,
	input wire logic       opStart,
	input wire logic       fmtSpared,
	input wire logic [7:0] fmtAddrMark,
	input wire logic [7:0] fmtSpareSlot,
	input wire logic [7:0] secPerTrack,
	input wire logic       driveReadyPin,
	input wire logic       driveFaultPin,
	input wire logic       driveIllegalPin,
	input wire logic       seekDonePin
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	logic termRd;
	// host read while the status byte is offered
	assign termRd = hostAlert && dataRdStb && !cmdWrStb;
	term_order_a: assert property ($rose(ctrlBusyLine) |=> $rose(hostAlert))
		else $error("alert did not follow busy release");
	code_range_a: assert property ($rose(hostAlert) |=> hostRdData[3:0] <= 4'h9)
		else $error("status code above nine");
	flags_clear_a: assert property ($rose(hostAlert) |=> hostRdData[3:0] == 4'h0 || hostRdData[7:4] == 4'h0)
		else $error("flags set beside an error code");
	alert_drop_a: assert property (termRd && !$rose(hostAlert) |=> !hostAlert)
		else $error("alert stayed after status read");
	aux_first_a: assert property (termRd && !$rose(hostAlert) |=>
		hostRdData == {seekDonePin, driveFaultPin, driveIllegalPin, 2'b00, !driveReadyPin, 2'b00})
		else $error("first auxiliary byte wrong");
	op_busy_a: assert property (opStart |-> !ctrlBusyLine)
		else $error("disk op started while idle");
	data_req_a: assert property (hostDataReq |-> !ctrlBusyLine && !hostAlert)
		else $error("data asked for outside execution");
	mark_spare_a: assert property (fmtSpareSlot < secPerTrack |=> fmtSpared && fmtAddrMark == 8'h7D)
		else $error("spared track mark wrong");
	mark_norm_a: assert property (fmtSpareSlot >= secPerTrack |=> !fmtSpared && fmtAddrMark == 8'h77)
		else $error("normal track mark wrong");
endmodule : dwcsr_props

bind dwcsr_ctrl dwcsr_props chk (.mclk, .arst_n, .cmdWrStb, .dataRdStb, .hostRdData, .ctrlBusyLine, .hostAlert,
	.hostDataReq, .opStart, .fmtSpared, .fmtAddrMark, .fmtSpareSlot, .secPerTrack, .driveReadyPin, .driveFaultPin,
	.driveIllegalPin, .seekDonePin);

// ==== verification/dwcsr_disk_model.sv ====
// Purpose: disk engine stand-in answering ops and draining the data FIFO
// Assumes: one op at a time, answers after a short or a long wait
// Notes:   when armed, fails the next errTimes ops of kind errKind
`timescale 1ns/100ps
module dwcsr_disk_model (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       arm,
	input  wire logic [3:0] errKind,
	input  wire logic [3:0] errCode,
	input  wire logic [7:0] errTimes,
	input  wire logic       opStart,
	input  wire logic [3:0] opKind,
	output logic            opDone,
	output logic      [3:0] opErr,
	output logic            diskReady
);
	logic [7:0] left_reg;
	logic [2:0] wait_reg;
	logic [1:0] tick_reg;
	logic       slow_reg;
	logic [3:0] kind_reg;
	// answer each op, alternating prompt and slow; code scrambled outside done
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{opDone, opErr, wait_reg, slow_reg, kind_reg, left_reg} <= '0;
		end else begin
			opDone <= 1'b0;
			opErr <= ~opErr;
			if (arm)
				left_reg <= errTimes;
			if (opStart) begin
				wait_reg <= slow_reg ? 3'h4 : 3'h1;
				slow_reg <= ~slow_reg;
				kind_reg <= opKind;
			end else if (wait_reg != 3'h0) begin
				wait_reg <= wait_reg - 3'h1;
				if (wait_reg == 3'h1) begin
					opDone <= 1'b1;
					opErr <= 4'h0;
					if (left_reg != 8'h00 && kind_reg == errKind) begin
						opErr <= errCode;
						left_reg <= left_reg - 8'h01;
					end
				end
			end
		end
	end
	// drain side stalls three cycles in four
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			tick_reg <= '0;
		else
			tick_reg <= tick_reg + 2'h1;
	end
	assign diskReady = (tick_reg == 2'h0);
endmodule : dwcsr_disk_model

// ==== verification/disk_write_cmd_status_retry_test.sv ====
// Purpose: host-side sequences of command, data and status reads
// Assumes: inputs change 1 ns after the rising edge
// Notes:   disk engine behaviour comes from dwcsr_disk_model
`timescale 1ns/100ps
module disk_write_cmd_status_retry_test;
	logic        mclk = 1'b0, arst_n = 1'b0, cmdWrStb = 1'b0, dataWrStb = 1'b0, dataRdStb = 1'b0;
	logic        eccFitted = 1'b0, arm = 1'b0, driveReadyPin = 1'b1, driveFaultPin = 1'b0;
	logic        driveIllegalPin = 1'b0, seekDonePin = 1'b1;
	logic  [7:0] hostWrData = 8'h00, secPerTrack = 8'h0C, errTimes = 8'h00;
	logic  [3:0] errCode = 4'h0, errKind = 4'h0, hdrHead = 4'hB;
	logic  [7:0] hdrCylLo = 8'h45, hdrCylHi = 8'h01, hdrSector = 8'h02, hdrMark = 8'h77;
	logic  [7:0] hostRdData, opSector, opSecCount, diskData, fmtAddrMark, fmtSpareSlot, curCmd;
	logic  [3:0] opKind, opHead, opErr;
	logic [10:0] opCyl;
	logic  [1:0] opUnit, posShift, shiftSeen;
	logic        ctrlBusyLine, hostAlert, hostDataReq, opStart, opTrackMode, opDone, fmtSpared, diskValid, diskReady;
	logic [47:0] curPar;
	int          miscompares = 0, compares = 0, cyc = 0;
	logic  [7:0] sent [$];
	// cmd, fail kind, fail code, fail count, status, status mask
	logic [39:0] plan [7] = '{40'h23_2801_08FF, 40'h0F_3701_40FF, 40'h07_1601_50FF, 40'h07_1401_60FF,
		40'h87_1701_07FF, 40'h07_17C8_07FF, 40'h07_1701_808F};

	dwcsr_ctrl dut (.mclk, .arst_n, .cmdWrStb, .dataWrStb, .dataRdStb, .hostWrData, .hostRdData, .ctrlBusyLine,
		.hostAlert, .hostDataReq, .opStart, .opKind, .opUnit, .opHead, .opCyl, .opSector, .opSecCount, .opTrackMode,
		.posShift, .opDone, .opErr, .eccFitted, .secPerTrack, .fmtSpared, .fmtAddrMark, .fmtSpareSlot, .hdrHead,
		.hdrCylLo, .hdrCylHi, .hdrSector, .hdrMark, .driveReadyPin, .driveFaultPin, .driveIllegalPin, .seekDonePin,
		.diskData, .diskValid, .diskReady);
	dwcsr_disk_model disk (.mclk, .arst_n, .arm, .errKind, .errCode, .errTimes, .opStart, .opKind, .opDone, .opErr,
		.diskReady);

	// 10 MHz clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	// host bytes reach the disk side in order
	always @(posedge mclk) begin
		if (dataWrStb && hostDataReq) begin
			sent.push_back(hostWrData);
		end
		if (diskValid && diskReady && sent.size() > 0) begin
			chk(diskData, sent.pop_front());
		end
	end

	// cycle ceiling against hangs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic send(input logic [7:0] b, input logic isCmd);
		@(posedge mclk);
		#1;
		cmdWrStb = isCmd;
		dataWrStb = !isCmd;
		hostWrData = b;
		@(posedge mclk);
		#1;
		cmdWrStb = 1'b0;
		dataWrStb = 1'b0;
		chk(hostRdData, b);
	endtask : send

	// command, six parameters, go, then feed data until the alert
	task automatic issue(input logic [7:0] c, input logic [47:0] p);
		curCmd = c;
		curPar = p;
		send(c, 1'b1);
		for (int i = 0; i < 6; i++) send(p[8*i+:8], 1'b0);
		@(posedge mclk);
		#1;
		dataWrStb = 1'b1;
		for (int n = 0; n < 3000 && !hostAlert; n++) begin
			@(posedge mclk);
			#1;
			dataWrStb = hostDataReq;
			hostWrData = hostWrData + 8'h01;
			shiftSeen = shiftSeen | posShift;
			if (opStart) begin
				chk(opUnit, p[1:0]);
				chk(opHead, p[7:4]);
				chk(opCyl, {p[18:16], p[15:8]});
				chk(opTrackMode, c[4]);
				chk(8'(opSector + opSecCount), 8'(p[31:24] + p[39:32]));
			end
		end
		dataWrStb = 1'b0;
		chk(hostAlert, 1'b1);
		chk(ctrlBusyLine, 1'b1);
	endtask : issue

	// status byte, seven auxiliary bytes, one filler
	task automatic finish(input logic [7:0] term, input logic [7:0] mask);
		logic [7:0] aux [9];
		aux = '{term, {seekDonePin, driveFaultPin, driveIllegalPin, 2'b00, !driveReadyPin, 2'b00}, curCmd,
			{hdrHead, 2'b00, curPar[1:0]}, hdrCylLo, hdrCylHi, hdrSector, hdrMark, 8'h00};
		for (int i = 0; i < 9; i++) begin
			@(posedge mclk);
			#1;
			dataRdStb = 1'b1;
			chk(i == 0 ? hostRdData & mask : hostRdData, aux[i]);
			@(posedge mclk);
			#1;
			dataRdStb = 1'b0;
			if (i == 0) chk(hostAlert, 1'b0);
		end
	endtask : finish

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// main sequence
	initial begin
		repeat (5) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		issue(8'h07, 48'h1002_0005_4532);
		chk(fmtAddrMark, 8'h77);
		finish(8'h00, 8'hFF);
		issue(8'h07, 48'h0301_0000_0012);
		chk({fmtSpared, fmtAddrMark}, 9'h17D);
		chk(fmtSpareSlot, 8'h03);
		finish(8'h00, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			driveReadyPin = (i != 2);
			repeat (3) @(posedge mclk);
			issue(i == 0 ? 8'h22 : 8'h07,
				i == 0 ? 48'h0001_0040_0000 : i == 1 ? 48'h0001_0008_0000 : 48'h0001_0000_0000);
			chk(posShift, i == 0 ? 2'b01 : 2'b00);
			finish(8'(i + 1), 8'hFF);
		end
		driveReadyPin = 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		for (int i = 0; i < 7; i++) begin
			{errKind, errCode, errTimes} = plan[i][31:16];
			eccFitted = (i == 6);
			arm = 1'b1;
			@(posedge mclk);
			#1;
			arm = 1'b0;
			shiftSeen = 2'b00;
			issue(plan[i][39:32], 48'h0001_0000_0000);
			finish(plan[i][15:8], plan[i][7:0]);
			if (i == 5) chk(shiftSeen, 2'b11);
		end
		stop_test();
	end
endmodule : disk_write_cmd_status_retry_test
